// ==== pkg/inst_exec_pkg.sv ====
// Package: constants, types and register map of the instruction executor
package inst_exec_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_INSTR   = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_ACK     = 8'h08;
  localparam logic [7:0] ADDR_DEST    = 8'h0C;
  localparam logic [7:0] ADDR_OFFS    = 8'h10;
  localparam logic [7:0] ADDR_LEN     = 8'h14;
  localparam logic [7:0] ADDR_QDATA   = 8'h18;
  localparam logic [7:0] ADDR_EVENT   = 8'h1C;
  // ----------------------------------------------------------------
  // Instruction codes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_SLEEP     = 8'h01;
  localparam logic [7:0] OP_WAKE      = 8'h02;
  localparam logic [7:0] OP_BUSY_ON   = 8'h03;
  localparam logic [7:0] OP_BUSY_OFF  = 8'h04;
  localparam logic [7:0] OP_BUS_RST   = 8'h11;
  localparam logic [7:0] OP_LINK_RST  = 8'h12;
  localparam logic [7:0] OP_LINK_INIT = 8'h13;
  localparam logic [7:0] OP_ROOT      = 8'h21;
  localparam logic [7:0] OP_GAP       = 8'h22;
  localparam logic [7:0] OP_LINK_ON   = 8'h23;
  localparam logic [7:0] OP_PING      = 8'h24;
  localparam logic [7:0] OP_WR_QUAD   = 8'h30;
  localparam logic [7:0] OP_WR_BLOCK  = 8'h31;
  // ----------------------------------------------------------------
  // Field positions and codes
  // ----------------------------------------------------------------
  localparam int          STAT_SLEEP_BIT = 4;
  localparam int          STAT_BUSY_BIT  = 5;
  localparam int          STAT_LRST_BIT  = 6;
  localparam int          STAT_RUN_BIT   = 7;
  localparam int          STAT_PEND_BIT  = 8;
  localparam int          EV_DONE_BIT    = 0;
  localparam int          EV_ERR_BIT     = 1;
  localparam int          EV_BOV_BIT     = 2;
  localparam int          EV_SID_BIT     = 3;
  localparam int          FIFO_SEL_BIT   = 3;
  localparam logic [2:0]  SPD_S100       = 3'h0;
  localparam logic [2:0]  SPD_S200       = 3'h1;
  localparam logic [2:0]  SPD_S400       = 3'h2;
  localparam logic [5:0]  PHY_BCAST      = 6'h3F;
  localparam logic [3:0]  ACK_BUSY_X     = 4'h4;
  localparam logic [1:0]  QUAD_MASK      = 2'h3;
  // Phy packet kinds driven on the phy request port
  localparam logic [1:0]  PHY_PKT_ROOT   = 2'h0;
  localparam logic [1:0]  PHY_PKT_GAP    = 2'h1;
  localparam logic [1:0]  PHY_PKT_LINKON = 2'h2;
  localparam logic [1:0]  PHY_PKT_PING   = 2'h3;

  typedef enum {
    ST_IDLE, ST_PHY_REQ, ST_BRST, ST_ARB, ST_SEND, ST_ACK
  } exec_st_t;

  // Async write request towards the packet engine
  typedef struct packed {
    logic        valid;
    logic        block;
    logic        fifo_sel;
    logic [2:0]  speed;
    logic [15:0] dest_id;
    logic [47:0] dest_off;
    logic [15:0] byte_cnt;
    logic [1:0]  pad_bytes;
    logic [31:0] quad;
  } wr_req_t;

  // Phy packet request
  typedef struct packed {
    logic        valid;
    logic [1:0]  kind;
    logic [5:0]  arg;
  } phy_req_t;
endpackage

// ==== hw/inst_exec.sv ====
// Instruction executor with APB register slave
`timescale 1ns/100ps
module inst_exec #(
  parameter int ACK_TIMEOUT = 1000
) (
  input  wire logic                    ref_clk,
  input  wire logic                    reset_n,
  // APB slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // Physical layer side
  input  wire logic [1:0]              cable_con,
  input  wire logic                    phy_traffic,
  input  wire logic                    self_id_done,
  input  wire logic                    arb_gap_seen,
  input  wire logic                    arb_won,
  input  wire logic                    arb_lost,
  input  wire logic                    tx_done,
  input  wire logic                    ack_valid,
  input  wire logic [3:0]              ack_code,
  input  wire logic                    rx_async,
  input  wire logic                    rx_bcast,
  input  wire logic                    rx_self_id,
  output logic                         sleep_out,
  output logic                         bus_rst_req,
  output logic                         gap_cnt_dis_clr,
  output logic                         arb_req,
  output logic                         link_accept_all,
  output logic                         rx_store,
  output logic                         busy_ack_send,
  output logic      [3:0]              busy_ack_code,
  output inst_exec_pkg::phy_req_t      phy_req,
  input  wire logic                    phy_req_done,
  output inst_exec_pkg::wr_req_t       wr_req
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    inst_exec_pkg::exec_st_t st;
    logic [7:0]  code;
    logic [7:0]  opnd;
    logic        sleep;
    logic        busy;
    logic        link_rst;
    logic        brst_pend;
    logic [3:0]  ack;
    logic [3:0]  events;
    logic [15:0] dest_id;
    logic [47:0] dest_off;
    logic [15:0] byte_cnt;
    logic [31:0] quad;
    logic [15:0] tmo;
    logic [31:0] rdata;
    logic        bsy_ack;
    inst_exec_pkg::phy_req_t phy;
    inst_exec_pkg::wr_req_t  wr;
  } state_t;

  state_t s_r, s_nxt;

  // Counter is 16 bits wide, so larger limits cannot be served
  if (ACK_TIMEOUT < 1 || ACK_TIMEOUT > 65535) begin : g_bad_timeout
    $error("ACK_TIMEOUT out of range");
  end

  function automatic logic speed_ok(input logic [2:0] spd);
    speed_ok = (spd == inst_exec_pkg::SPD_S100) ||
               (spd == inst_exec_pkg::SPD_S200) ||
               (spd == inst_exec_pkg::SPD_S400);
  endfunction

  logic wr_acc, rd_acc;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && !penable && !pwrite;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] c;
    logic [7:0] o;
    c = pwdata[15:8];
    o = pwdata[7:0];
    s_nxt = s_r;
    s_nxt.bsy_ack = 1'b0;
    s_nxt.phy.valid = s_r.phy.valid && !phy_req_done;

    // Registers reachable in any state, sleep included
    if (wr_acc) begin
      case (paddr)
        inst_exec_pkg::ADDR_DEST:  s_nxt.dest_id = pwdata[15:0];
        inst_exec_pkg::ADDR_OFFS:  s_nxt.dest_off[31:0] = pwdata;
        inst_exec_pkg::ADDR_LEN: begin
          s_nxt.byte_cnt = pwdata[15:0];
          s_nxt.dest_off[47:32] = pwdata[31:16];
        end
        inst_exec_pkg::ADDR_QDATA: s_nxt.quad = pwdata;
        inst_exec_pkg::ADDR_EVENT:
          s_nxt.events = s_r.events & ~pwdata[3:0];
        default: ;
      endcase
    end

    // Self-ID or non-broadcast async receipt enters busy mode
    if (rx_async && !rx_bcast)
      s_nxt.busy = 1'b1;
    if (rx_self_id)
      s_nxt.busy = 1'b1;
    // Busy answers ack_busy_X, packet dropped
    if (rx_async && !rx_bcast && (s_r.busy || s_r.link_rst))
      s_nxt.bsy_ack = s_r.busy;

    // Instruction fetch, only when idle
    if (wr_acc && paddr == inst_exec_pkg::ADDR_INSTR &&
        s_r.st == inst_exec_pkg::ST_IDLE) begin
      s_nxt.code = c;
      s_nxt.opnd = o;
      case (c)
        inst_exec_pkg::OP_SLEEP:    s_nxt.sleep = 1'b1;
        inst_exec_pkg::OP_WAKE:     s_nxt.sleep = 1'b0;
        inst_exec_pkg::OP_BUSY_ON:  s_nxt.busy = 1'b1;
        inst_exec_pkg::OP_BUSY_OFF: s_nxt.busy = 1'b0;
        inst_exec_pkg::OP_BUS_RST: begin
          s_nxt.brst_pend = 1'b1;
          s_nxt.st = inst_exec_pkg::ST_BRST;
          if (cable_con == 2'b00)
            s_nxt.events[inst_exec_pkg::EV_BOV_BIT] = 1'b1;
        end
        inst_exec_pkg::OP_LINK_RST: begin
          s_nxt.link_rst = 1'b1;
          s_nxt.wr.valid = 1'b0;
          s_nxt.phy.valid = 1'b0;
          s_nxt.brst_pend = 1'b0;
        end
        inst_exec_pkg::OP_LINK_INIT: s_nxt.link_rst = 1'b0;
        inst_exec_pkg::OP_ROOT, inst_exec_pkg::OP_GAP,
        inst_exec_pkg::OP_LINK_ON, inst_exec_pkg::OP_PING: begin
          if (!s_r.link_rst && !s_r.sleep) begin
            s_nxt.phy.valid = 1'b1;
            s_nxt.phy.arg = o[5:0];
            s_nxt.phy.kind = c[1:0] - 2'h1;
            s_nxt.st = inst_exec_pkg::ST_PHY_REQ;
          end
        end
        inst_exec_pkg::OP_WR_QUAD, inst_exec_pkg::OP_WR_BLOCK: begin
          // Bad speed code: nothing starts
          if (speed_ok(o[2:0]) && !s_r.link_rst && !s_r.sleep) begin
            s_nxt.wr.block = c[0];
            s_nxt.wr.fifo_sel = o[inst_exec_pkg::FIFO_SEL_BIT];
            s_nxt.wr.speed = o[2:0];
            s_nxt.wr.dest_id = s_r.dest_id;
            s_nxt.wr.dest_off = s_r.dest_off;
            s_nxt.wr.byte_cnt = s_r.byte_cnt;
            s_nxt.wr.pad_bytes = 2'(-s_r.byte_cnt[1:0]) &
                                 inst_exec_pkg::QUAD_MASK;
            s_nxt.wr.quad = s_r.quad;
            s_nxt.st = inst_exec_pkg::ST_ARB;
          end
        end
        default: ;
      endcase
    end

    case (s_r.st)
      inst_exec_pkg::ST_IDLE: ;
      inst_exec_pkg::ST_PHY_REQ:
        if (phy_req_done || !s_r.phy.valid) begin
          s_nxt.st = inst_exec_pkg::ST_IDLE;
          s_nxt.events[inst_exec_pkg::EV_DONE_BIT] = 1'b1;
        end
      inst_exec_pkg::ST_BRST: begin
        // Held while the bus carries traffic
        if (s_r.brst_pend && !phy_traffic)
          s_nxt.brst_pend = 1'b0;
        if (!s_r.brst_pend && self_id_done) begin
          s_nxt.st = inst_exec_pkg::ST_IDLE;
          s_nxt.events[inst_exec_pkg::EV_SID_BIT] = 1'b1;
        end
      end
      inst_exec_pkg::ST_ARB:
        if (arb_gap_seen && arb_won) begin
          s_nxt.wr.valid = 1'b1;
          s_nxt.st = inst_exec_pkg::ST_SEND;
        end else if (arb_lost) begin
          s_nxt.st = inst_exec_pkg::ST_IDLE;
          s_nxt.events[inst_exec_pkg::EV_ERR_BIT] = 1'b1;
        end
      inst_exec_pkg::ST_SEND:
        if (tx_done) begin
          s_nxt.wr.valid = 1'b0;
          s_nxt.tmo = 16'(ACK_TIMEOUT);
          if (s_r.wr.dest_id[5:0] == inst_exec_pkg::PHY_BCAST) begin
            s_nxt.st = inst_exec_pkg::ST_IDLE;
            s_nxt.events[inst_exec_pkg::EV_DONE_BIT] = 1'b1;
          end else
            s_nxt.st = inst_exec_pkg::ST_ACK;
        end
      inst_exec_pkg::ST_ACK:
        if (ack_valid) begin
          s_nxt.ack = ack_code;
          s_nxt.st = inst_exec_pkg::ST_IDLE;
          s_nxt.events[inst_exec_pkg::EV_DONE_BIT] = 1'b1;
        end else if (s_r.tmo == 16'h0000) begin
          s_nxt.st = inst_exec_pkg::ST_IDLE;
          s_nxt.events[inst_exec_pkg::EV_ERR_BIT] = 1'b1;
        end else
          s_nxt.tmo = s_r.tmo - 16'h0001;
      default: s_nxt.st = inst_exec_pkg::ST_IDLE;
    endcase

    // Link reset aborts anything running
    if (wr_acc && paddr == inst_exec_pkg::ADDR_INSTR &&
        c == inst_exec_pkg::OP_LINK_RST) begin
      s_nxt.st = inst_exec_pkg::ST_IDLE;
      s_nxt.wr.valid = 1'b0;
      s_nxt.phy.valid = 1'b0;
      s_nxt.link_rst = 1'b1;
    end

    // Read data captured in setup phase, one-wait-free answer
    if (rd_acc) begin
      s_nxt.rdata = 32'h0000_0000;
      case (paddr)
        inst_exec_pkg::ADDR_INSTR:
          s_nxt.rdata[15:0] = {s_r.code, s_r.opnd};
        inst_exec_pkg::ADDR_STATUS: begin
          s_nxt.rdata[inst_exec_pkg::STAT_SLEEP_BIT] = s_r.sleep;
          s_nxt.rdata[inst_exec_pkg::STAT_BUSY_BIT] = s_r.busy;
          s_nxt.rdata[inst_exec_pkg::STAT_LRST_BIT] = s_r.link_rst;
          s_nxt.rdata[inst_exec_pkg::STAT_RUN_BIT] =
            (s_r.st != inst_exec_pkg::ST_IDLE);
          s_nxt.rdata[inst_exec_pkg::STAT_PEND_BIT] = s_r.brst_pend;
        end
        inst_exec_pkg::ADDR_ACK:   s_nxt.rdata[3:0] = s_r.ack;
        inst_exec_pkg::ADDR_DEST:  s_nxt.rdata[15:0] = s_r.dest_id;
        inst_exec_pkg::ADDR_OFFS:  s_nxt.rdata = s_r.dest_off[31:0];
        inst_exec_pkg::ADDR_LEN:
          s_nxt.rdata = {s_r.dest_off[47:32], s_r.byte_cnt};
        inst_exec_pkg::ADDR_QDATA: s_nxt.rdata = s_r.quad;
        inst_exec_pkg::ADDR_EVENT: s_nxt.rdata[3:0] = s_r.events;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      s_r <= '0;
      s_r.st <= inst_exec_pkg::ST_IDLE;
    end else
      s_r <= s_nxt;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= inst_exec_pkg::ADDR_EVENT);
  endfunction

  assign pready          = 1'b1;
  assign pslverr         = psel && penable && !mapped(paddr);
  assign prdata          = s_r.rdata;
  assign sleep_out       = s_r.sleep;
  assign bus_rst_req     = (s_r.st == inst_exec_pkg::ST_BRST) &&
                           !s_r.brst_pend;
  assign gap_cnt_dis_clr = bus_rst_req && self_id_done;
  assign arb_req         = (s_r.st == inst_exec_pkg::ST_ARB);
  assign link_accept_all = !s_r.link_rst;
  assign rx_store        = (rx_async && !s_r.busy &&
                            (!s_r.link_rst || rx_bcast));
  assign busy_ack_send   = s_r.bsy_ack;
  assign busy_ack_code   = inst_exec_pkg::ACK_BUSY_X;
  assign phy_req         = s_r.phy;
  assign wr_req          = s_r.wr;
endmodule // inst_exec

// ==== tb/inst_exec_asserts.sv ====
// Checker: port-level properties of the instruction executor
`timescale 1ns/100ps
module inst_exec_asserts (
  input wire logic                 ref_clk,
  input wire logic                 reset_n,
  input wire logic                 rx_async,
  input wire logic                 rx_bcast,
  input wire logic                 rx_store,
  input wire logic                 link_accept_all,
  input wire logic                 busy_ack_send,
  input wire logic [3:0]           busy_ack_code,
  input wire logic                 sleep_out,
  input wire logic                 phy_traffic,
  input wire logic                 bus_rst_req,
  input wire logic                 arb_won,
  input wire logic                 arb_req,
  input wire logic                 arb_gap_seen,
  input wire logic                 tx_done,
  input wire logic                 phy_req_done,
  input inst_exec_pkg::phy_req_t   phy_req,
  input inst_exec_pkg::wr_req_t    wr_req
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence s_granted;
    arb_req && arb_gap_seen && arb_won;
  endsequence
  sequence s_phy_wait;
    phy_req.valid && !phy_req_done;
  endsequence
  a_busy_code: assert property (busy_ack_send |->
    busy_ack_code == inst_exec_pkg::ACK_BUSY_X &&
    $past(rx_async && !rx_bcast)) else $error("bad busy ack");
  a_busy_discard: assert property (busy_ack_send |-> !$past(rx_store))
    else $error("busy packet stored");
  a_bcast_only: assert property (
    rx_async && !rx_bcast && !link_accept_all |-> !rx_store)
    else $error("non-broadcast stored in link reset");
  a_arb_first: assert property ($rose(wr_req.valid) |->
    $past(arb_gap_seen && arb_won)) else $error("send without arbitration");
  a_arb_grant: assert property (s_granted |=> $rose(wr_req.valid))
    else $error("grant not followed by send");
  a_tx_release: assert property (wr_req.valid && tx_done |=>
    !wr_req.valid) else $error("request held after send");
  a_phy_hold: assert property (s_phy_wait |=>
    phy_req.valid && $stable(phy_req)) else $error("phy request dropped");
  a_pad_zero: assert property (wr_req.valid && wr_req.block |->
    2'(wr_req.byte_cnt[1:0] + wr_req.pad_bytes) == 2'h0) else $error("bad pad");
  a_speed_ok: assert property (wr_req.valid |-> wr_req.speed <= 3'h2)
    else $error("reserved speed sent");
  a_sleep_quiet: assert property (sleep_out |->
    !wr_req.valid && !phy_req.valid) else $error("bus activity in sleep");
  a_rst_held: assert property ($rose(bus_rst_req) |->
    !$past(phy_traffic)) else $error("bus reset during traffic");
endmodule // inst_exec_asserts

bind inst_exec inst_exec_asserts inst_exec_asserts_inst (.*);

// ==== tb/node_responder.sv ====
// Far-side model: physical layer and remote nodes
`timescale 1ns/100ps
module node_responder (
  input  wire logic                ref_clk,
  input  wire logic                arb_req,
  input  wire logic                bus_rst_req,
  input  wire logic                mute,
  input  wire logic [3:0]          ack_val,
  input  inst_exec_pkg::phy_req_t  phy_req,
  input  inst_exec_pkg::wr_req_t   wr_req,
  output logic                     arb_gap_seen,
  output logic                     arb_won,
  output logic                     tx_done,
  output logic                     ack_valid,
  output logic [3:0]               ack_code,
  output logic                     phy_req_done,
  output logic                     self_id_done
);
  int tx_cnt = 0;
  int ack_cnt = 0;
  int phy_cnt = 0;
  int sid_cnt = 0;
  initial begin
    {arb_gap_seen, arb_won, tx_done, ack_valid} = 4'h0;
    {phy_req_done, self_id_done, ack_code} = 6'h0;
  end
  always @(posedge ref_clk) begin
    arb_gap_seen <= arb_req;
    arb_won <= arb_req && arb_gap_seen && !arb_won;
    tx_cnt <= (wr_req.valid && !tx_done) ? tx_cnt + 1 : 0;
    tx_done <= wr_req.valid && tx_cnt == 4;
    // Stale ack lines toggle so a late sample never matches by luck
    ack_code <= ~ack_code;
    ack_valid <= ack_cnt == 3;
    if (ack_cnt == 3)
      ack_code <= ack_val;
    // Broadcast writes are never acknowledged
    if (tx_done && !mute && wr_req.dest_id[5:0] != inst_exec_pkg::PHY_BCAST)
      ack_cnt <= 1;
    else
      ack_cnt <= (ack_cnt > 0 && ack_cnt < 3) ? ack_cnt + 1 : 0;
    phy_cnt <= (phy_req.valid && !phy_req_done) ? phy_cnt + 1 : 0;
    phy_req_done <= phy_req.valid && phy_cnt == 3;
    sid_cnt <= bus_rst_req ? sid_cnt + 1 : 0;
    self_id_done <= bus_rst_req && sid_cnt == 5;
  end
endmodule // node_responder

// ==== tb/inst_exec_tb.sv ====
// Self-checking bench for the instruction executor
`timescale 1ns/100ps
module inst_exec_tb;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rv;
  logic        pready, pslverr, perr, stored, acked;
  logic [1:0]  cable_con = 2'h1;
  logic        phy_traffic = 1'b0;
  logic        rx_async = 1'b0;
  logic        rx_bcast = 1'b0;
  logic        rx_self_id = 1'b0;
  logic        arb_lost = 1'b0;
  logic        mute = 1'b0;
  logic [3:0]  ack_val = 4'h1;
  logic        arb_gap_seen, arb_won, tx_done, ack_valid, phy_req_done;
  logic        self_id_done, sleep_out, bus_rst_req, gap_cnt_dis_clr;
  logic        arb_req, link_accept_all, rx_store, busy_ack_send;
  logic [3:0]  ack_code, busy_ack_code;
  inst_exec_pkg::phy_req_t phy_req;
  inst_exec_pkg::wr_req_t  wr_req;
  int          error_cnt = 0;
  int          checked = 0;
  int          gap_hits = 0;

  always #10 ref_clk = ~ref_clk;
  inst_exec #(.ACK_TIMEOUT(8)) inst_exec_inst (.*);
  node_responder node_responder_inst (.*);

  // Counts gap flag clear pulses seen by the phy side
  always @(posedge ref_clk)
    if (gap_cnt_dis_clr === 1'b1)
      gap_hits <= gap_hits + 1;

  // ------
  // Shared tasks
  // ------
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rv = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic instr(input logic [7:0] c, input logic [7:0] o);
    apb(1'b1, inst_exec_pkg::ADDR_INSTR, {16'h0, c, o});
  endtask
  // Bounded poll of the running flag
  task automatic run_wait();
    rv = 32'hFFFFFFFF;
    for (int n = 0; n < 200 && rv[inst_exec_pkg::STAT_RUN_BIT]; n++)
      rd(inst_exec_pkg::ADDR_STATUS);
    chk(rv[inst_exec_pkg::STAT_RUN_BIT], 1'b0);
  endtask
  task automatic ev(input logic [3:0] m, input logic [3:0] e);
    rd(inst_exec_pkg::ADDR_EVENT);
    chk(rv[3:0] & m, e);
    apb(1'b1, inst_exec_pkg::ADDR_EVENT, 32'hF);
  endtask
  task automatic rx(input logic b);
    rx_bcast <= b;
    rx_async <= 1'b1;
    @(negedge ref_clk);
    stored = rx_store;
    @(posedge ref_clk);
    rx_async <= 1'b0;
    @(negedge ref_clk);
    acked = busy_ack_send;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] o,
                    input logic [15:0] d, input logic [15:0] n,
                    input logic [3:0] e);
    apb(1'b1, inst_exec_pkg::ADDR_DEST, {16'h0, d});
    apb(1'b1, inst_exec_pkg::ADDR_LEN, {16'h0, n});
    apb(1'b1, inst_exec_pkg::ADDR_QDATA, {16'hC0DE, n});
    instr(c, o);
    for (int k = 0; k < 20 && !wr_req.valid; k++) @(posedge ref_clk);
    if (o[2:0] > 3'h2)
      chk({arb_req, wr_req.valid}, 2'h0);
    else
      chk({wr_req.block, wr_req.fifo_sel, wr_req.speed, wr_req.dest_id,
           wr_req.byte_cnt}, {c[0], o[3:0], d, n});
    if (!c[0] && o[2:0] < 3'h3)
      chk(wr_req.quad, {16'hC0DE, n});
    run_wait();
    ev(4'h3, e);
  endtask

  // ------
  // Scenarios
  // ------
  task automatic t_sleep();
    instr(inst_exec_pkg::OP_SLEEP, 8'h00);
    rd(inst_exec_pkg::ADDR_STATUS);
    chk({sleep_out, rv[inst_exec_pkg::STAT_SLEEP_BIT]}, 2'h3);
    apb(1'b1, inst_exec_pkg::ADDR_OFFS, 32'h5A5AC3C3);
    rd(inst_exec_pkg::ADDR_OFFS);
    chk(rv, 32'h5A5AC3C3);
    instr(inst_exec_pkg::OP_PING, 8'h07);
    chk(phy_req.valid, 1'b0);
    instr(inst_exec_pkg::OP_WAKE, 8'h00);
    rd(inst_exec_pkg::ADDR_STATUS);
    chk({sleep_out, rv[inst_exec_pkg::STAT_SLEEP_BIT]}, 2'h0);
    $display("sleep test done");
  endtask
  task automatic t_busy();
    instr(inst_exec_pkg::OP_BUSY_ON, 8'h00);
    rx(1'b0);
    chk({stored, acked, busy_ack_code}, 6'h14);
    instr(inst_exec_pkg::OP_BUSY_OFF, 8'h00);
    rx(1'b0);
    rd(inst_exec_pkg::ADDR_STATUS);
    chk({stored, acked, rv[inst_exec_pkg::STAT_BUSY_BIT]}, 3'h5);
    instr(inst_exec_pkg::OP_BUSY_OFF, 8'h00);
    rd(inst_exec_pkg::ADDR_STATUS);
    chk(rv[inst_exec_pkg::STAT_BUSY_BIT], 1'b0);
    rx_self_id <= 1'b1;
    @(posedge ref_clk);
    rx_self_id <= 1'b0;
    rd(inst_exec_pkg::ADDR_STATUS);
    chk(rv[inst_exec_pkg::STAT_BUSY_BIT], 1'b1);
    instr(inst_exec_pkg::OP_BUSY_OFF, 8'h00);
    rd(inst_exec_pkg::ADDR_STATUS);
    chk(rv[inst_exec_pkg::STAT_BUSY_BIT], 1'b0);
    $display("busy test done");
  endtask
  task automatic t_link();
    instr(inst_exec_pkg::OP_LINK_RST, 8'h00);
    rx(1'b1);
    chk({link_accept_all, stored}, 2'h1);
    rx(1'b0);
    chk(stored, 1'b0);
    instr(inst_exec_pkg::OP_LINK_INIT, 8'h00);
    chk(link_accept_all, 1'b1);
    instr(inst_exec_pkg::OP_BUSY_OFF, 8'h00);
    $display("link test done");
  endtask
  // Codes 21h..24h map in order onto the four phy packet kinds
  task automatic t_phy();
    for (int k = 0; k < 4; k++) begin
      instr(inst_exec_pkg::OP_ROOT + 8'(k), 8'h2C + 8'(k));
      chk({phy_req.valid, phy_req.kind, phy_req.arg},
          {1'b1, 2'(k), 6'h2C + 6'(k)});
      run_wait();
      ev(4'h3, 4'h1);
    end
    $display("phy packet test done");
  endtask
  task automatic t_brst();
    phy_traffic <= 1'b1;
    instr(inst_exec_pkg::OP_BUS_RST, 8'h00);
    rd(inst_exec_pkg::ADDR_STATUS);
    chk({bus_rst_req, rv[inst_exec_pkg::STAT_PEND_BIT]}, 2'h1);
    phy_traffic <= 1'b0;
    run_wait();
    ev(4'hF, 4'h8);
    chk(gap_hits, 1);
    cable_con <= 2'h0;
    instr(inst_exec_pkg::OP_BUS_RST, 8'h00);
    run_wait();
    ev(4'h4, 4'h4);
    cable_con <= 2'h1;
    $display("bus reset test done");
  endtask
  task automatic t_wr();
    ack_val <= 4'h2;
    wr(inst_exec_pkg::OP_WR_QUAD, 8'h09, 16'hFFC5, 16'h4, 4'h1);
    rd(inst_exec_pkg::ADDR_ACK);
    chk(rv[3:0], 4'h2);
    wr(inst_exec_pkg::OP_WR_BLOCK, 8'h02, 16'hFFC5, 16'h5, 4'h1);
    wr(inst_exec_pkg::OP_WR_BLOCK, 8'h01, 16'hFFFF, 16'h7, 4'h1);
    mute <= 1'b1;
    wr(inst_exec_pkg::OP_WR_QUAD, 8'h00, 16'hFFC1, 16'h4, 4'h2);
    mute <= 1'b0;
    wr(inst_exec_pkg::OP_WR_QUAD, 8'h03, 16'hFFC1, 16'h4, 4'h0);
    arb_lost <= 1'b1;
    wr(inst_exec_pkg::OP_WR_QUAD, 8'h00, 16'hFFC1, 16'h4, 4'h2);
    arb_lost <= 1'b0;
    instr(8'h45, 8'h00);
    rd(inst_exec_pkg::ADDR_STATUS);
    chk({arb_req, phy_req.valid, rv[inst_exec_pkg::STAT_RUN_BIT]},
        3'h0);
    rd(8'h22);
    chk({perr, rv}, {1'b1, 32'h0});
    $display("write test done");
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    t_sleep();
    t_busy();
    t_link();
    t_phy();
    t_brst();
    t_wr();
    tally_and_finish();
  end
  // Tests need a few hundred cycles; 20000 means a hang
  initial begin
    #400000;
    error_cnt++;
    tally_and_finish();
  end
endmodule // inst_exec_tb
